//--- src/ctlc_defines.svh
// Purpose: constants of the thread-safe tracking leaf checker
// Assumes: 32-bit register port, byte offsets
// Notes: exit codes, page type encodings and register offsets are local choices
`ifndef CTLC_DEFINES_SVH
`define CTLC_DEFINES_SVH

// leaf selection
`define CTLC_LEAF_CODE 32'h0000_0011
`define CTLC_FEATURE_BIT 6
// 4 KByte boundary: low 12 address bits
`define CTLC_PAGE_BITS 12
// accumulator return values
`define CTLC_RET_OK 64'h0000_0000_0000_0000
`define CTLC_RET_PAGE_INVALID 64'h0000_0000_0000_0006
`define CTLC_RET_PAGE_CONFLICT 64'h0000_0000_0000_0007
`define CTLC_RET_PRIOR_TRK_INCOMPLETE 64'h0000_0000_0000_0011
`define CTLC_RET_TRK_NOT_NEEDED 64'h0000_0000_0000_001B
// page types in the page cache map entry
`define CTLC_PT_CONTROL_STRUCTURE 8'h00
`define CTLC_PT_THREAD_CONTROL 8'h01
`define CTLC_PT_REGULAR 8'h02
`define CTLC_PT_TRIMMED 8'h04
`define CTLC_FIRST_SHADOW_STACK_PAGE_TYPE 8'h05
`define CTLC_REST_SHADOW_STACK_PAGE_TYPE 8'h06
// virtualization exit
`define CTLC_EXIT_REASON_CONFLICT 16'h003F
`define CTLC_QUAL_RESOURCE_CONFLICT 16'h0001
`define CTLC_QUAL_REFERENCE_CONFLICT 16'h0002
// flag vector positions
`define CTLC_FLAG_CF 0
`define CTLC_FLAG_PF 1
`define CTLC_FLAG_AF 2
`define CTLC_FLAG_ZF 3
`define CTLC_FLAG_SF 4
`define CTLC_FLAG_OF 5
// register offsets
`define CTLC_REG_CTRL 8'h00
`define CTLC_REG_STATUS 8'h04
`define CTLC_REG_ENABLE 8'h08
`define CTLC_REG_CLEAR 8'h0C
// status bits
`define CTLC_ST_SUCCESS 0
`define CTLC_ST_ERROR 1
`define CTLC_ST_GP 2
`define CTLC_ST_PF 3
`define CTLC_ST_EXIT 4
`define CTLC_ST_WIDTH 5
// reset values
`define CTLC_CTRL_RESET 32'h0000_0040
`define CTLC_ENABLE_RESET 5'h00

`endif

//--- src/ctlc_pkg.sv
// Purpose: types of the thread-safe tracking leaf checker
// Assumes: nothing
// Notes: state encoding is gray along idle to eval
package ctlc_pkg;

    typedef enum logic [0:0]
    {
        CTLC_IDLE = 1'b0,
        CTLC_EVAL = 1'b1
    } ctlc_state_t;

    typedef enum logic [2:0]
    {
        CTLC_OC_OK = 3'h0,
        CTLC_OC_ERR = 3'h1,
        CTLC_OC_GP = 3'h2,
        CTLC_OC_PF = 3'h3,
        CTLC_OC_EXIT = 3'h4
    } ctlc_outcome_t;

endpackage

//--- src/ctlc_track_leaf.sv
// Purpose: thread-safe tracking leaf of the enclave system instruction
// Assumes: lookups arrive with the request, same clock; result two edges later
// Notes: faults and exits leave accumulator and flags untouched
`timescale 1ns/10ps
`include "ctlc_defines.svh"
`default_nettype none

module ctlc_track_leaf
    import ctlc_pkg::*;
#(
    parameter int ADDR_W = 64
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // instruction request
    input wire logic req_valid,
    input wire logic [31:0] req_leaf,
    input wire logic [1:0] req_cpl,
    input wire logic req_long_mode,
    input wire logic req_protected,
    input wire logic req_canonical,
    input wire logic req_segment_ok,
    input wire logic req_guest,
    input wire logic req_virt_ctrl,
    input wire logic [ADDR_W-1:0] req_page_ptr,
    // page cache map and structure lookups
    input wire logic map_in_cache,
    input wire logic map_access_fault,
    input wire logic map_valid,
    input wire logic [7:0] map_page_type,
    input wire logic [ADDR_W-1:0] map_owner_ptr,
    input wire logic [ADDR_W-1:0] struct_context,
    input wire logic struct_tracking,
    input wire logic track_busy_other,
    input wire logic page_busy_excl,
    // completion
    output logic done_q,
    output logic leaf_miss_q,
    output logic result_valid_q,
    output logic [63:0] acc_q,
    output logic [5:0] flags_q,
    output logic fault_gp_q,
    output logic fault_pf_q,
    output logic [ADDR_W-1:0] fault_addr_q,
    // virtualization exit
    output logic vm_exit_q,
    output logic [15:0] exit_reason_q,
    output logic [15:0] exit_qual_q,
    output logic [15:0] exit_error_q,
    output logic [ADDR_W-1:0] exit_gpa_q,
    output logic [ADDR_W-1:0] exit_gla_q,
    // tracking facility
    output logic track_claim_q,
    output logic track_start_q,
    output logic [ADDR_W-1:0] struct_addr_q,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q,
    // interrupt
    output logic irq_q
);

    // refuse address widths the page offset and result ports cannot serve
    if (ADDR_W < `CTLC_PAGE_BITS + 1 || ADDR_W > 64)
    begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end

    function automatic logic ctlc_aligned(input logic [ADDR_W-1:0] a);
        ctlc_aligned = (a[`CTLC_PAGE_BITS-1:0] == '0);
    endfunction

    ctlc_state_t state_q;
    logic [31:0] ctrl_q;
    logic [`CTLC_ST_WIDTH-1:0] status_q;
    logic [`CTLC_ST_WIDTH-1:0] enable_q;
    logic [`CTLC_ST_WIDTH-1:0] set_ev;
    logic leaf_sel;
    logic accept;
    // captured request
    logic [1:0] c_cpl;
    logic c_long, c_prot, c_canon, c_seg, c_guest, c_virt;
    logic [ADDR_W-1:0] c_ptr;
    logic c_in_cache, c_afault, c_valid, c_track, c_busy, c_pbusy;
    logic [7:0] c_type;
    logic [ADDR_W-1:0] c_owner;
    logic [ADDR_W-1:0] c_ctx;
    // evaluation
    ctlc_outcome_t oc;
    logic [63:0] oc_code;
    logic oc_zf;
    logic oc_cf;
    logic [15:0] oc_qual;
    logic type_owned;
    logic type_struct;
    logic no_fault;
    logic [ADDR_W-1:0] owner_addr;

    assign leaf_sel = (req_leaf == `CTLC_LEAF_CODE) && ctrl_q[`CTLC_FEATURE_BIT];
    assign accept = req_valid && (state_q == CTLC_IDLE) && leaf_sel;

    assign type_owned = (c_type == `CTLC_PT_REGULAR) || (c_type == `CTLC_PT_THREAD_CONTROL)
        || (c_type == `CTLC_PT_TRIMMED) || (c_type == `CTLC_FIRST_SHADOW_STACK_PAGE_TYPE)
        || (c_type == `CTLC_REST_SHADOW_STACK_PAGE_TYPE);
    assign type_struct = (c_type == `CTLC_PT_CONTROL_STRUCTURE);
    assign owner_addr = type_struct ? c_ptr : c_owner;
    // no fault of any kind before the map checks
    assign no_fault = (c_cpl == 2'h0) && !(c_long && !c_canon) && !(!c_long && c_prot && !c_seg)
        && ctlc_aligned(c_ptr) && c_in_cache && !c_afault;

    // sequencing
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state_q <= CTLC_IDLE;
        else if (state_q == CTLC_IDLE && accept)
            state_q <= CTLC_EVAL;
        else
            state_q <= CTLC_IDLE;
    end

    // request capture
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            c_cpl <= 2'h0;
            {c_long, c_prot, c_canon, c_seg, c_guest, c_virt} <= 6'h00;
            {c_in_cache, c_afault, c_valid, c_track, c_busy, c_pbusy} <= 6'h00;
            c_ptr <= '0;
            c_type <= 8'h00;
            c_owner <= '0;
            c_ctx <= '0;
        end
        else if (accept)
        begin
            c_cpl <= req_cpl;
            {c_long, c_prot, c_canon, c_seg} <= {req_long_mode, req_protected,
                req_canonical, req_segment_ok};
            {c_guest, c_virt} <= {req_guest, req_virt_ctrl};
            c_ptr <= req_page_ptr;
            {c_in_cache, c_afault, c_valid} <= {map_in_cache, map_access_fault, map_valid};
            {c_track, c_busy, c_pbusy} <= {struct_tracking, track_busy_other, page_busy_excl};
            c_type <= map_page_type;
            c_owner <= map_owner_ptr;
            c_ctx <= struct_context;
        end
    end

    // checks in priority order
    always_comb
    begin
        oc = CTLC_OC_OK;
        oc_code = `CTLC_RET_OK;
        oc_zf = 1'b0;
        oc_cf = 1'b0;
        oc_qual = 16'h0000;
        if (c_cpl != 2'h0)
            oc = CTLC_OC_GP;
        else if (c_long && !c_canon)
            oc = CTLC_OC_GP;
        else if (!c_long && c_prot && !c_seg)
            oc = CTLC_OC_GP;
        else if (!ctlc_aligned(c_ptr))
            oc = CTLC_OC_GP;
        else if (!c_in_cache || c_afault)
            oc = CTLC_OC_PF;
        else if (!c_valid)
        begin
            oc = CTLC_OC_ERR;
            oc_code = `CTLC_RET_PAGE_INVALID;
            oc_zf = 1'b1;
        end
        else if (!type_owned && !type_struct)
        begin
            oc = CTLC_OC_ERR;
            oc_code = `CTLC_RET_TRK_NOT_NEEDED;
            oc_cf = 1'b1;
        end
        else if (c_busy || c_pbusy)
        begin
            oc = (c_guest && c_virt) ? CTLC_OC_EXIT : CTLC_OC_ERR;
            oc_qual = `CTLC_QUAL_RESOURCE_CONFLICT;
            oc_code = `CTLC_RET_PAGE_CONFLICT;
            oc_zf = 1'b1;
        end
        else if (c_track)
        begin
            oc = (c_guest && c_virt) ? CTLC_OC_EXIT : CTLC_OC_ERR;
            oc_qual = `CTLC_QUAL_REFERENCE_CONFLICT;
            oc_code = `CTLC_RET_PRIOR_TRK_INCOMPLETE;
            oc_zf = 1'b1;
        end
    end

    // completion strobes
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            done_q <= 1'b0;
            leaf_miss_q <= 1'b0;
            result_valid_q <= 1'b0;
            fault_gp_q <= 1'b0;
            fault_pf_q <= 1'b0;
            vm_exit_q <= 1'b0;
            track_start_q <= 1'b0;
        end
        else
        begin
            done_q <= (state_q == CTLC_EVAL);
            leaf_miss_q <= req_valid && (state_q == CTLC_IDLE) && !leaf_sel;
            result_valid_q <= (state_q == CTLC_EVAL)
                && (oc == CTLC_OC_OK || oc == CTLC_OC_ERR);
            fault_gp_q <= (state_q == CTLC_EVAL) && (oc == CTLC_OC_GP);
            fault_pf_q <= (state_q == CTLC_EVAL) && (oc == CTLC_OC_PF);
            vm_exit_q <= (state_q == CTLC_EVAL) && (oc == CTLC_OC_EXIT);
            track_start_q <= (state_q == CTLC_EVAL) && (oc == CTLC_OC_OK);
        end
    end

    // architectural results, held between completions
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            acc_q <= 64'h0;
            flags_q <= 6'h00;
        end
        else if (state_q == CTLC_EVAL && (oc == CTLC_OC_OK || oc == CTLC_OC_ERR))
        begin
            acc_q <= oc_code;
            flags_q <= 6'h00;
            flags_q[`CTLC_FLAG_ZF] <= oc_zf;
            flags_q[`CTLC_FLAG_CF] <= oc_cf;
        end
    end

    // fault, exit and structure details
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            fault_addr_q <= '0;
            exit_reason_q <= 16'h0000;
            exit_qual_q <= 16'h0000;
            exit_error_q <= 16'h0000;
            exit_gpa_q <= '0;
            exit_gla_q <= '0;
            struct_addr_q <= '0;
        end
        else if (state_q == CTLC_EVAL)
        begin
            fault_addr_q <= (oc == CTLC_OC_PF) ? c_ptr : '0;
            struct_addr_q <= owner_addr;
            if (oc == CTLC_OC_EXIT)
            begin
                exit_reason_q <= `CTLC_EXIT_REASON_CONFLICT;
                exit_qual_q <= oc_qual;
                exit_error_q <= 16'h0000;
                exit_gpa_q <= c_ctx;
                exit_gla_q <= '0;
            end
        end
    end

    // exclusive hold on the structure's tracking facility
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            track_claim_q <= 1'b0;
        else
            track_claim_q <= accept;
    end

    // register port and interrupt
    // error return is either flag set on a result
    assign set_ev = {vm_exit_q, fault_pf_q, fault_gp_q,
        result_valid_q && (flags_q[`CTLC_FLAG_ZF] || flags_q[`CTLC_FLAG_CF]),
        track_start_q};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_q <= `CTLC_CTRL_RESET;
            enable_q <= `CTLC_ENABLE_RESET;
        end
        else if (reg_wr && reg_addr == `CTLC_REG_CTRL)
            ctrl_q <= reg_wdata;
        else if (reg_wr && reg_addr == `CTLC_REG_ENABLE)
            enable_q <= reg_wdata[`CTLC_ST_WIDTH-1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            status_q <= '0;
        else if (reg_wr && reg_addr == `CTLC_REG_CLEAR)
            status_q <= (status_q & ~reg_wdata[`CTLC_ST_WIDTH-1:0]) | set_ev;
        else
            status_q <= status_q | set_ev;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reg_rdata_q <= 32'h0;
        else if (reg_rd && reg_addr == `CTLC_REG_CTRL)
            reg_rdata_q <= ctrl_q;
        else if (reg_rd && reg_addr == `CTLC_REG_STATUS)
            reg_rdata_q <= {{(32-`CTLC_ST_WIDTH){1'b0}}, status_q};
        else if (reg_rd && reg_addr == `CTLC_REG_ENABLE)
            reg_rdata_q <= {{(32-`CTLC_ST_WIDTH){1'b0}}, enable_q};
        else
            reg_rdata_q <= 32'h0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_q <= 1'b0;
        else
            irq_q <= |(status_q & enable_q);
    end

    // checks
    property p_leaf_gate;
        @(posedge sys_clk) disable iff (rst)
        req_valid && state_q == CTLC_IDLE && req_leaf != `CTLC_LEAF_CODE
        |=> leaf_miss_q ##1 !done_q;
    endproperty
    a_leaf_gate: assert property (p_leaf_gate) else $error("wrong leaf completed");

    property p_priv;
        @(posedge sys_clk) disable iff (rst)
        accept && req_cpl != 2'h0 |-> ##2 done_q && fault_gp_q && !result_valid_q;
    endproperty
    a_priv: assert property (p_priv) else $error("nonzero privilege not faulted");

    property p_align;
        @(posedge sys_clk) disable iff (rst)
        state_q == CTLC_EVAL && c_cpl == 2'h0 && !(c_long && !c_canon) && !ctlc_aligned(c_ptr)
        |=> fault_gp_q && !fault_pf_q;
    endproperty
    a_align: assert property (p_align) else $error("unaligned pointer not faulted");

    property p_invalid;
        @(posedge sys_clk) disable iff (rst)
        state_q == CTLC_EVAL && no_fault && !c_valid
        |=> result_valid_q && acc_q == `CTLC_RET_PAGE_INVALID && flags_q == 6'h08;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid page result wrong");

    property p_not_needed;
        @(posedge sys_clk) disable iff (rst)
        state_q == CTLC_EVAL && no_fault && c_valid && !type_owned && !type_struct
        |=> acc_q == `CTLC_RET_TRK_NOT_NEEDED && flags_q == 6'h01 && !track_start_q;
    endproperty
    a_not_needed: assert property (p_not_needed) else $error("type result wrong");

    property p_conflict_exit;
        @(posedge sys_clk) disable iff (rst)
        state_q == CTLC_EVAL && no_fault && c_valid && (type_owned || type_struct)
        && c_busy && c_guest && c_virt
        |=> vm_exit_q && exit_qual_q == `CTLC_QUAL_RESOURCE_CONFLICT && exit_gla_q == '0
        && exit_gpa_q == $past(c_ctx);
    endproperty
    a_conflict_exit: assert property (p_conflict_exit) else $error("conflict exit wrong");

    property p_conflict_err;
        @(posedge sys_clk) disable iff (rst)
        state_q == CTLC_EVAL && no_fault && c_valid && (type_owned || type_struct)
        && c_busy && !c_guest
        |=> acc_q == `CTLC_RET_PAGE_CONFLICT && flags_q[`CTLC_FLAG_ZF];
    endproperty
    a_conflict_err: assert property (p_conflict_err) else $error("conflict code wrong");

    property p_prior;
        @(posedge sys_clk) disable iff (rst)
        state_q == CTLC_EVAL && no_fault && c_valid && (type_owned || type_struct)
        && !c_busy && !c_pbusy && c_track && !c_guest
        |=> acc_q == `CTLC_RET_PRIOR_TRK_INCOMPLETE && flags_q == 6'h08;
    endproperty
    a_prior: assert property (p_prior) else $error("prior tracking result wrong");

    property p_success;
        @(posedge sys_clk) disable iff (rst)
        track_start_q |-> result_valid_q && acc_q == `CTLC_RET_OK && flags_q == 6'h00;
    endproperty
    a_success: assert property (p_success) else $error("success result wrong");

    property p_misc_clear;
        @(posedge sys_clk) disable iff (rst)
        result_valid_q |-> !flags_q[`CTLC_FLAG_PF] && !flags_q[`CTLC_FLAG_AF]
        && !flags_q[`CTLC_FLAG_OF] && !flags_q[`CTLC_FLAG_SF];
    endproperty
    a_misc_clear: assert property (p_misc_clear) else $error("misc flags not clear");

    property p_hold;
        @(posedge sys_clk) disable iff (rst)
        done_q && !result_valid_q |-> $stable(acc_q) && $stable(flags_q);
    endproperty
    a_hold: assert property (p_hold) else $error("results changed on fault");

    property p_owner;
        @(posedge sys_clk) disable iff (rst)
        state_q == CTLC_EVAL && type_struct |=> struct_addr_q == $past(c_ptr);
    endproperty
    a_owner: assert property (p_owner) else $error("owner address wrong");

endmodule

`default_nettype wire

//--- testbench/ctlc_sw_model.sv
// Purpose: software side issuing the tracking leaf, with its lookups
// Assumes: bench spaces commands as the request order allows
// Notes: idle lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none

module ctlc_sw_model
(
    // clock
    input wire logic sys_clk,
    // command from bench
    input wire logic go,
    input wire logic [21:0] cmd,
    input wire logic [31:0] leaf,
    input wire logic [63:0] ptr,
    input wire logic [63:0] ctx,
    // request and lookups
    output logic req_valid,
    output logic [31:0] req_leaf,
    output logic [21:0] req_bits,
    output logic [63:0] req_ptr,
    output logic [63:0] req_ctx
);
    initial
    begin
        req_valid = 1'b0;
        req_leaf = 32'h0;
        req_bits = 22'h0;
        req_ptr = 64'h0;
        req_ctx = 64'h0;
    end

    // all lookups travel with the strobe
    always @(posedge sys_clk)
    begin
        req_valid <= go;
        req_leaf <= go ? leaf : ~req_leaf;
        req_bits <= go ? cmd : ~req_bits;
        req_ptr <= go ? ptr : ~req_ptr;
        req_ctx <= go ? ctx : ~req_ctx;
    end
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Purpose: self-checking bench of the tracking leaf checker
// Assumes: ctlc_sw_model drives requests and lookups
// Notes: expected results queued in issue order
`timescale 1ns/10ps
`include "ctlc_defines.svh"
`default_nettype none

module tb;
    localparam logic [21:0] BASE = 22'h0853C;
    localparam logic [21:0] MASKS [0:25] = '{22'h0, 22'h1, 22'h3, 22'h10, 22'h24, 22'h4,
        22'hC, 22'h100, 22'h200, 22'h400, 22'h4000, 22'h4400, 22'h8000, 22'hC000,
        22'h18000, 22'h1C000, 22'h10000, 22'h14000, 22'h800, 22'h8C0, 22'h840, 22'h1000,
        22'h2000, 22'h20C0, 22'h2080, 22'h2800};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [21:0] cmd = 22'h0;
    logic [31:0] leaf = 32'h0;
    logic [63:0] ptr = 64'h0;
    logic [63:0] ctx = 64'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic req_valid, done_q, leaf_miss_q, result_valid_q, fault_gp_q, fault_pf_q;
    logic vm_exit_q, irq_q, track_start_q;
    logic [31:0] req_leaf, reg_rdata_q;
    logic [21:0] req_bits;
    logic [63:0] req_ptr, req_ctx, acc_q, fault_addr_q, exit_gpa_q, exit_gla_q;
    logic [63:0] struct_addr_q;
    logic [5:0] flags_q;
    logic [15:0] exit_reason_q, exit_qual_q, exit_error_q;
    logic [319:0] exp_q [$];
    logic [319:0] got;
    logic [63:0] l_acc = 64'h0;
    logic [63:0] l_sa = 64'h0;
    logic [63:0] l_fa = 64'h0;
    logic [63:0] l_gpa = 64'h0;
    logic [5:0] l_fl = 6'h0;
    logic [15:0] l_q = 16'h0;
    logic [15:0] l_rs = 16'h0;
    logic feat = 1'b1;
    logic [31:0] r;
    logic [21:0] c;
    int num_errors = 0;
    int n_tests = 0;
    int seed = 32'h2FBD;

    ctlc_sw_model u_ctlc_sw_model (.sys_clk(sys_clk), .go(go), .cmd(cmd), .leaf(leaf),
        .ptr(ptr), .ctx(ctx), .req_valid(req_valid), .req_leaf(req_leaf),
        .req_bits(req_bits), .req_ptr(req_ptr), .req_ctx(req_ctx));

    ctlc_track_leaf u_ctlc_track_leaf (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
        .req_leaf(req_leaf), .req_cpl(req_bits[1:0]), .req_long_mode(req_bits[2]),
        .req_protected(req_bits[3]), .req_canonical(req_bits[4]),
        .req_segment_ok(req_bits[5]), .req_guest(req_bits[6]), .req_virt_ctrl(req_bits[7]),
        .req_page_ptr(req_ptr), .map_in_cache(req_bits[8]), .map_access_fault(req_bits[9]),
        .map_valid(req_bits[10]), .map_page_type(req_bits[21:14]),
        .map_owner_ptr(~req_ctx), .struct_context(req_ctx), .struct_tracking(req_bits[13]),
        .track_busy_other(req_bits[11]), .page_busy_excl(req_bits[12]), .done_q(done_q),
        .leaf_miss_q(leaf_miss_q), .result_valid_q(result_valid_q), .acc_q(acc_q),
        .flags_q(flags_q), .fault_gp_q(fault_gp_q), .fault_pf_q(fault_pf_q),
        .fault_addr_q(fault_addr_q), .vm_exit_q(vm_exit_q), .exit_reason_q(exit_reason_q),
        .exit_qual_q(exit_qual_q), .exit_error_q(exit_error_q), .exit_gpa_q(exit_gpa_q),
        .exit_gla_q(exit_gla_q), .track_claim_q(), .track_start_q(track_start_q),
        .struct_addr_q(struct_addr_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q));

    always #2.5 sys_clk = ~sys_clk;

    task automatic chk(input logic [319:0] g, input logic [319:0] e);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task summarize;
        $display("tests=%0d errors=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata_q, e);
    endtask

    // gap below zero holds the strobe a second cycle, which must be ignored
    task issue(input logic [21:0] cc, input logic un, input logic [31:0] lf, input int gap);
        logic [2:0] oc;
        logic [15:0] q;
        logic [63:0] code;
        logic [63:0] p;
        logic [63:0] x;
        oc = 3'h1;
        q = 16'h0;
        code = 64'h0;
        p = ({$random(seed), $random(seed)} & ~64'hFFF) | (un ? 64'h8 : 64'h0);
        x = {$random(seed), $random(seed)};
        if (lf !== 32'h11 || !feat) oc = 3'h5;
        else if (cc[1:0] != 2'h0) oc = 3'h2;
        else if (cc[2] && !cc[4]) oc = 3'h2;
        else if (!cc[2] && cc[3] && !cc[5]) oc = 3'h2;
        else if (un) oc = 3'h2;
        else if (!cc[8] || cc[9]) oc = 3'h3;
        else if (!cc[10]) code = 64'h6;
        else if (!(cc[21:14] inside {`CTLC_PT_CONTROL_STRUCTURE, `CTLC_PT_THREAD_CONTROL,
            `CTLC_PT_REGULAR, `CTLC_PT_TRIMMED, `CTLC_FIRST_SHADOW_STACK_PAGE_TYPE, `CTLC_REST_SHADOW_STACK_PAGE_TYPE}))
            code = 64'h1B;
        else if (cc[11] || cc[12])
        begin
            oc = (cc[6] && cc[7]) ? 3'h4 : 3'h1;
            q = `CTLC_QUAL_RESOURCE_CONFLICT;
            code = 64'h7;
        end
        else if (cc[13])
        begin
            oc = (cc[6] && cc[7]) ? 3'h4 : 3'h1;
            q = `CTLC_QUAL_REFERENCE_CONFLICT;
            code = 64'h11;
        end
        else oc = 3'h0;
        if (oc <= 3'h1)
        begin
            l_acc = code;
            l_fl = (code == 64'h1B) ? 6'h01 : ((code == 64'h0) ? 6'h00 : 6'h08);
        end
        if (oc <= 3'h4)
        begin
            l_fa = (oc == 3'h3) ? p : 64'h0;
            l_sa = (cc[21:14] == `CTLC_PT_CONTROL_STRUCTURE) ? p : ~x;
        end
        if (oc == 3'h4)
        begin
            l_gpa = x;
            l_q = q;
            l_rs = `CTLC_EXIT_REASON_CONFLICT;
        end
        exp_q.push_back({oc == 3'h5, oc == 3'h2, oc == 3'h3, oc == 3'h4, oc <= 3'h1,
            oc == 3'h0, l_fl, l_acc, l_fa, l_gpa, l_q, l_rs, 16'h0, 1'b0, l_sa});
        @(posedge sys_clk);
        go <= 1'b1;
        cmd <= cc;
        leaf <= lf;
        ptr <= p;
        ctx <= x;
        if (gap < 0) @(posedge sys_clk);
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (gap < 0 ? 3 : gap) @(posedge sys_clk);
    endtask

    // fault and exit leave acc and flags as they were
    always @(negedge sys_clk)
        if (done_q === 1'b1 || leaf_miss_q === 1'b1)
        begin
            got = {leaf_miss_q, fault_gp_q, fault_pf_q, vm_exit_q, result_valid_q,
                track_start_q, flags_q, acc_q, fault_addr_q, exit_gpa_q, exit_qual_q,
                exit_reason_q, exit_error_q, |exit_gla_q, struct_addr_q};
            if (exp_q.size() == 0) chk(got, ~got);
            else chk(got, exp_q.pop_front());
        end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h00, 32'h40);
        rd(8'h08, 32'h0);
        rd(8'h10, 32'h0);
        wr(8'h04, 32'h1F);
        rd(8'h04, 32'h0);
        foreach (MASKS[i]) issue(BASE ^ MASKS[i], 1'b0, 32'h11, 4);
        issue(BASE ^ 22'h100, 1'b1, 32'h11, 4);
        issue(BASE, 1'b0, 32'h0C, 4);
        issue(BASE, 1'b0, 32'h11, -1);
        wr(8'h00, 32'h0);
        feat = 1'b0;
        issue(BASE, 1'b0, 32'h11, 4);
        wr(8'h00, 32'h40);
        feat = 1'b1;
        for (int i = 0; i < 60; i++)
        begin
            r = $random(seed);
            c = {5'h0, r[16:0]};
            c[1:0] = c[1:0] & {2{r[26]}};
            c[10] = c[10] | r[27];
            c[9] = c[9] & r[28];
            issue(c, r[22] & r[23], (r[24] & r[25]) ? 32'h0C : 32'h11, 0);
        end
        // let the last random request reach status before clearing it
        repeat (4) @(posedge sys_clk);
        wr(8'h0C, 32'h1F);
        wr(8'h08, 32'h1F);
        rd(8'h08, 32'h1F);
        issue(BASE, 1'b0, 32'h11, 8);
        @(negedge sys_clk);
        chk(irq_q, 1'b1);
        rd(8'h04, 32'h01);
        wr(8'h0C, 32'h01);
        repeat (3) @(negedge sys_clk);
        chk(irq_q, 1'b0);
        wr(8'h08, 32'h0);
        issue(BASE ^ 22'h400, 1'b0, 32'h11, 8);
        @(negedge sys_clk);
        chk(irq_q, 1'b0);
        rd(8'h04, 32'h02);
        for (int k = 0; k < 50 && exp_q.size() != 0; k++) @(posedge sys_clk);
        if (exp_q.size() != 0) num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
